// [logic/drive_status_word_upper.sv]
// Local design decisions: strobed register access and the register offsets.
`timescale 1ns/1ps
`include "status_word_defines.svh"

module drive_status_word_upper (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [15:0] reg_rdata,
    input wire logic cmd_from_network,
    input wire status_word_pkg::drive_mode_t drive_mode,
    input wire logic [15:0] speed_reference,
    input wire logic [15:0] actual_speed,
    input wire logic other_ref_reached,
    input wire logic other_ref_limited,
    input wire logic stop_key_stop,
    input wire logic reverse_output,
    input wire logic [8:0] lower_status,
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////
    // state
    status_word_pkg::word_t status_word;
    status_word_pkg::word_t next_status_word;
    status_word_pkg::word_t irq_status;
    status_word_pkg::word_t next_irq_status;
    status_word_pkg::word_t irq_mask;
    status_word_pkg::word_t next_irq_mask;
    status_word_pkg::word_t low_speed_limit;
    status_word_pkg::word_t next_low_speed_limit;
    status_word_pkg::word_t high_speed_limit;
    status_word_pkg::word_t next_high_speed_limit;
    status_word_pkg::word_t reach_window;
    status_word_pkg::word_t next_reach_window;
    status_word_pkg::word_t next_rdata;
    logic [16:0] diff;
    logic reached;
    logic limited;

    ////////////////////////////////////////////////////////////////////////
    // condition evaluation
    always_comb begin
        // absolute speed error, one extra bit so the subtraction cannot wrap
        if (actual_speed >= speed_reference) begin
            diff = {1'b0, actual_speed} - {1'b0, speed_reference};
        end else begin
            diff = {1'b0, speed_reference} - {1'b0, actual_speed};
        end
        if (drive_mode == status_word_pkg::MODE_SPEED) begin
            reached = (diff <= {1'b0, reach_window});
            limited = (speed_reference < low_speed_limit) ||
                (speed_reference > high_speed_limit);
        end else begin
            // torque-type modes supply their own verdicts
            reached = other_ref_reached;
            limited = other_ref_limited;
        end
    end

    // whole word rebuilt each cycle so a read never sees a mixed update
    always_comb begin
        next_status_word = `STATUS_WORD_RESET;
        next_status_word[8:0] = lower_status;
        next_status_word[`BIT_REMOTE] = cmd_from_network;
        next_status_word[`BIT_REACHED] = reached;
        next_status_word[`BIT_LIMIT] = limited;
        next_status_word[`BIT_RSVD0] = 1'b0;
        next_status_word[`BIT_RSVD1] = 1'b0;
        next_status_word[`BIT_STOP_KEY] = stop_key_stop;
        next_status_word[`BIT_DIRECTION] = reverse_output;
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            status_word <= `STATUS_WORD_RESET;
        end else begin
            status_word <= next_status_word;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // software registers and interrupt
    always_comb begin
        next_irq_mask = irq_mask;
        next_low_speed_limit = low_speed_limit;
        next_high_speed_limit = high_speed_limit;
        next_reach_window = reach_window;
        next_irq_status = irq_status;
        if (reg_write) begin
            case (reg_addr)
                `IRQ_STATUS_OFFSET: begin
                    next_irq_status = irq_status & ~reg_wdata;
                end
                `IRQ_MASK_OFFSET: begin
                    next_irq_mask = reg_wdata;
                end
                `LOW_SPEED_LIMIT_OFFSET: begin
                    next_low_speed_limit = reg_wdata;
                end
                `HIGH_SPEED_LIMIT_OFFSET: begin
                    next_high_speed_limit = reg_wdata;
                end
                `REACH_WINDOW_OFFSET: begin
                    next_reach_window = reg_wdata;
                end
                default: begin
                    next_irq_mask = irq_mask;
                end
            endcase
        end
        // any status bit change is an event; set beats a same-cycle clear
        next_irq_status = next_irq_status | (next_status_word ^ status_word);
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            irq_status <= `IRQ_RESET;
            irq_mask <= `IRQ_RESET;
            low_speed_limit <= `LOW_SPEED_LIMIT_RESET;
            high_speed_limit <= `HIGH_SPEED_LIMIT_RESET;
            reach_window <= `REACH_WINDOW_RESET;
        end else begin
            irq_status <= next_irq_status;
            irq_mask <= next_irq_mask;
            low_speed_limit <= next_low_speed_limit;
            high_speed_limit <= next_high_speed_limit;
            reach_window <= next_reach_window;
        end
    end

    assign irq = |(irq_status & irq_mask);

    ////////////////////////////////////////////////////////////////////////
    // read data, valid the cycle after the strobe; unmapped reads give zero
    always_comb begin
        next_rdata = 16'h0000;
        if (reg_read) begin
            case (reg_addr)
                `STATUS_WORD_OFFSET: next_rdata = status_word;
                `IRQ_STATUS_OFFSET: next_rdata = irq_status;
                `IRQ_MASK_OFFSET: next_rdata = irq_mask;
                `LOW_SPEED_LIMIT_OFFSET: next_rdata = low_speed_limit;
                `HIGH_SPEED_LIMIT_OFFSET: next_rdata = high_speed_limit;
                `REACH_WINDOW_OFFSET: next_rdata = reach_window;
                default: next_rdata = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 16'h0000;
        end else begin
            reg_rdata <= next_rdata;
        end
    end

endmodule

// [logic/status_word_defines.svh]
`ifndef STATUS_WORD_DEFINES_SVH
`define STATUS_WORD_DEFINES_SVH
// Functional notes
// - bit 9 is 0 for terminal command source, 1 for network source.
// - bit 10 is 1 once the active reference is reached, else 0.
// - in speed mode the reached check uses the speed reference.
// - bit 11 is 1 while the reference lies outside its limits.
// - in speed mode limits are low speed and high speed settings.
// - bits 12 and 13 are reserved and carry no meaning.
// - bit 14 is 1 when the terminal stop key triggered a stop.
// - bit 15 gives output direction: 0 forward, 1 reverse.

////////////////////////////////////////////////////////////////////////
// register offsets (word index)
`define STATUS_WORD_OFFSET 4'h0
`define IRQ_STATUS_OFFSET 4'h1
`define IRQ_MASK_OFFSET 4'h2
`define LOW_SPEED_LIMIT_OFFSET 4'h3
`define HIGH_SPEED_LIMIT_OFFSET 4'h4
`define REACH_WINDOW_OFFSET 4'h5

// status word field positions
`define BIT_REMOTE 9
`define BIT_REACHED 10
`define BIT_LIMIT 11
`define BIT_RSVD0 12
`define BIT_RSVD1 13
`define BIT_STOP_KEY 14
`define BIT_DIRECTION 15

// reset values
`define STATUS_WORD_RESET 16'h0000
`define IRQ_RESET 16'h0000
`define LOW_SPEED_LIMIT_RESET 16'h0000
`define HIGH_SPEED_LIMIT_RESET 16'hffff
`define REACH_WINDOW_RESET 16'h0000
`endif

// [logic/status_word_pkg.sv]
package status_word_pkg;
    // control mode of the drive
    typedef enum logic [0:0] {
        MODE_SPEED,
        MODE_OTHER
    } drive_mode_t;
    typedef logic [15:0] word_t;
endpackage

// [verification/status_word_properties.sv]
`timescale 1ns/1ps
module status_word_properties (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [3:0] reg_addr,
    input wire logic reg_read,
    input wire logic [15:0] reg_rdata,
    input wire logic cmd_from_network,
    input wire status_word_pkg::drive_mode_t drive_mode,
    input wire logic other_ref_reached,
    input wire logic other_ref_limited,
    input wire logic stop_key_stop,
    input wire logic reverse_output,
    input wire logic [8:0] lower_status,
    input wire logic irq
);
////////////////////////////////////////
default clocking @(posedge core_clk); endclocking
default disable iff (rst);
// status read: bit follows the input seen two edges back
property rd_bit(int b, logic src);
    $past(reg_read) && $past(reg_addr) == 4'h0 |-> reg_rdata[b] == $past(src, 2);
endproperty
sequence st_rd;
    $past(reg_read) && $past(reg_addr) == 4'h0;
endsequence
chk_rdata_idle: assert property (!$past(reg_read) |-> reg_rdata == 16'h0000)
    else $error("read data not zero outside a read");
chk_rsvd_zero: assert property (st_rd |-> reg_rdata[13:12] == 2'h0)
    else $error("reserved status bits not zero");
chk_remote_bit: assert property (rd_bit(9, cmd_from_network))
    else $error("remote bit wrong");
chk_stop_key: assert property (rd_bit(14, stop_key_stop))
    else $error("stop key bit wrong");
chk_direction_bit: assert property (rd_bit(15, reverse_output))
    else $error("direction bit wrong");
chk_lower_bits: assert property (st_rd |-> reg_rdata[8:0] == $past(lower_status, 2))
    else $error("lower status bits wrong");
chk_reached_other: assert property (st_rd ##0 $past(drive_mode, 2) ==
    status_word_pkg::MODE_OTHER |-> reg_rdata[10] == $past(other_ref_reached, 2))
    else $error("reached bit wrong");
chk_limit_other: assert property (st_rd ##0 $past(drive_mode, 2) ==
    status_word_pkg::MODE_OTHER |-> reg_rdata[11] == $past(other_ref_limited, 2))
    else $error("limit bit wrong");
cover property (st_rd ##0 reg_rdata[15]);
cover property ($rose(irq));
cover property (st_rd ##0 reg_rdata[11:10] == 2'h3);
endmodule

// [verification/status_reader.sv]
`timescale 1ns/1ps
module status_reader (
    input wire logic core_clk,
    output logic [3:0] reg_addr = 4'h0,
    output logic [15:0] reg_wdata = 16'h0000,
    output logic reg_write = 1'b0,
    output logic reg_read = 1'b0,
    input wire logic [15:0] reg_rdata
);
////////////////////////////////////////
// one-cycle strobes; the slave never stalls
task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge core_clk);
    reg_write <= 1'b0;
endtask
// data stand only in the cycle after the strobe
task rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge core_clk);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
endtask
endmodule

// [verification/testbench.sv]
`timescale 1ns/1ps
module testbench;
logic core_clk = 0, rst = 1, net = 0, stop = 0, rev = 0, ore = 0, olim = 0, irq;
logic [15:0] sref = 0, act = 0, rd, reg_wdata, reg_rdata;
logic [8:0] low = 0;
logic [3:0] reg_addr;
logic reg_write, reg_read;
status_word_pkg::drive_mode_t mode = status_word_pkg::MODE_SPEED;
int n_errors = 0, n_checks = 0;
status_reader host(.core_clk(core_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata));
drive_status_word_upper DUT(.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .cmd_from_network(net), .drive_mode(mode),
    .speed_reference(sref), .actual_speed(act), .other_ref_reached(ore),
    .other_ref_limited(olim), .stop_key_stop(stop), .reverse_output(rev),
    .lower_status(low), .irq(irq));
////////////////////////////////////////
// 50 MHz clock
initial forever #10 core_clk = ~core_clk;
task check(string what, logic [15:0] exp, logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
        n_errors++;
        $display("wrong value %s expected %h seen %h", what, exp, got);
    end
endtask
task rd_check(string what, logic [3:0] a, logic [15:0] exp);
    host.rd(a, rd);
    check(what, exp, rd);
endtask
// flags are network, stop key, reverse, reached, limited
task apply(logic [4:0] f, status_word_pkg::drive_mode_t m, logic [15:0] s, a,
    logic [8:0] lo, logic [15:0] exp);
    @(posedge core_clk);
    {net, stop, rev, ore, olim} <= f;
    mode <= m;
    sref <= s;
    act <= a;
    low <= lo;
    repeat (2) @(posedge core_clk);
    rd_check("status word", 4'h0, exp);
endtask
task t_reset_values;
    rd_check("mask", 4'h2, 16'h0000);
    rd_check("high limit", 4'h4, 16'hffff);
    rd_check("unmapped", 4'h6, 16'h0000);
    host.wr(4'h0, 16'h3000);
    rd_check("read only status", 4'h0, 16'h0400);
endtask
task t_bits;
    apply(5'h1f, status_word_pkg::MODE_OTHER, 0, 0, 9'h1ff, 16'hcfff);
    apply(5'h15, status_word_pkg::MODE_OTHER, 0, 0, 9'h0a5, 16'h8aa5);
    apply(5'h02, status_word_pkg::MODE_OTHER, 0, 0, 9'h000, 16'h0400);
endtask
// boundaries of both limits and of the reach window
task t_speed;
    host.wr(4'h3, 16'h0064);
    host.wr(4'h4, 16'h00c8);
    host.wr(4'h5, 16'h0005);
    apply(5'h00, status_word_pkg::MODE_SPEED, 16'h00c9, 16'h00c4, 0, 16'h0c00);
    apply(5'h00, status_word_pkg::MODE_SPEED, 16'h0063, 16'h005e, 0, 16'h0c00);
    apply(5'h00, status_word_pkg::MODE_SPEED, 16'h0064, 16'h006a, 0, 16'h0000);
endtask
task t_irq;
    host.wr(4'h2, 16'h8000);
    host.wr(4'h1, 16'hffff);
    @(negedge core_clk) check("irq cleared", 0, {15'h0, irq});
    apply(5'h04, status_word_pkg::MODE_SPEED, 16'h0064, 16'h006a, 0, 16'h8000);
    check("irq raised", 1, {15'h0, irq});
    host.wr(4'h2, 16'h0000);
    @(negedge core_clk) check("irq masked", 0, {15'h0, irq});
    host.wr(4'h2, 16'h8000);
    host.wr(4'h1, 16'h8000);
    @(negedge core_clk) check("irq w1c", 0, {15'h0, irq});
endtask
task end_of_test;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
endtask
// main sequence after a four cycle reset
initial begin
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    t_reset_values;
    t_bits;
    t_speed;
    t_irq;
    end_of_test;
end
// watchdog: the run needs well under 200 cycles
initial begin
    #20000;
    n_errors++;
    end_of_test;
end
endmodule
bind drive_status_word_upper status_word_properties chk (.core_clk(core_clk), .rst(rst),
    .reg_addr(reg_addr), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .cmd_from_network(cmd_from_network), .drive_mode(drive_mode),
    .other_ref_reached(other_ref_reached), .other_ref_limited(other_ref_limited),
    .stop_key_stop(stop_key_stop), .reverse_output(reverse_output),
    .lower_status(lower_status), .irq(irq));
